/* logic/usc_consts.vh */
`ifndef USC_CONSTS_VH
`define USC_CONSTS_VH
`define USC_FRAME_CONFIG_OFS   4'h0
`define USC_BIT_TX_EDGE        6
`define USC_BIT_RX_EDGE        5
`define USC_BIT_EXT_CLK        4
`define USC_BIT_DATA_SIZE      3
`define USC_BIT_STOP           2
`define USC_BIT_PAR_TYPE       1
`define USC_BIT_PAR_EN         0
`define USC_TX_CNT_8           4'h9
`define USC_TX_CNT_7           4'h8
`define USC_CFG_WMASK          8'h7F
`define USC_CFG_RESET          8'h00
`define USC_FIFO_WIDTH         8
`define USC_FIFO_DEPTH         16
`define USC_FIFO_AW            4
`endif

/* logic/usc_fifo.v */
`default_nettype none
module usc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             core_clk,
   input  wire             nrst,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output reg  [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr;
   reg [AW:0]      rd_ptr;
   wire            full;
   wire            empty;
   wire            push;
   wire            pop;

   assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
   assign empty     = (wr_ptr == rd_ptr);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign push      = in_valid && !full;
   assign pop       = out_ready && !empty;

   always @*
   begin
      out_data = mem[rd_ptr[AW-1:0]];
   end

   always @(posedge core_clk)
   begin
      if (push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule // usc_fifo
`default_nettype wire

/* logic/usc_top.v */
`include "usc_consts.vh"
`default_nettype none
module usc_top (
   input  wire       core_clk,
   input  wire       nrst,
   input  wire [3:0] reg_addr,
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   input  wire       receiver_enable,
   input  wire       transmitter_enable,
   input  wire       baud_tick,
   input  wire       dpll_sample,
   input  wire       ext_clk_pin,
   input  wire       rx_pin,
   output reg        tx_pin,
   input  wire [7:0] tx_data,
   input  wire       tx_valid,
   output wire       tx_ready,
   output wire [7:0] rx_data,
   output wire       rx_valid,
   input  wire       rx_ready,
   output wire       ext_sample_clock_enable,
   output wire       data_size_select,
   output wire       stop_bit_select,
   output wire       parity_type_select,
   output wire       parity_enable,
   output wire       tx_bit_strobe,
   output wire       rx_bit_strobe,
   output reg        rx_bit
);
   // ----------------------------------------
   // Frame config register
   // ----------------------------------------
   reg  [6:0] uart_frame_config;
   reg  [6:0] next_cfg;
   wire       cfg_sel;
   wire       uart_idle;
   wire       tx_edge_select;
   wire       rx_edge_select;

   assign cfg_sel   = (reg_addr == `USC_FRAME_CONFIG_OFS);
   assign uart_idle = !receiver_enable && !transmitter_enable;

   always @*
   begin
      next_cfg = uart_frame_config;
      if (reg_wr && cfg_sel && uart_idle)
      begin
         next_cfg = reg_wdata[6:0];
      end
   end

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         uart_frame_config <= 7'h00;
      else
         uart_frame_config <= next_cfg;
   end

   always @*
   begin
      if (reg_rd && cfg_sel)
         reg_rdata = {1'b0, uart_frame_config};
      else
         reg_rdata = 8'h00;
   end

   assign tx_edge_select          = uart_frame_config[`USC_BIT_TX_EDGE];
   assign rx_edge_select          = uart_frame_config[`USC_BIT_RX_EDGE];
   assign ext_sample_clock_enable = uart_frame_config[`USC_BIT_EXT_CLK];
   assign data_size_select        = uart_frame_config[`USC_BIT_DATA_SIZE];
   assign stop_bit_select         = uart_frame_config[`USC_BIT_STOP];
   assign parity_type_select      = uart_frame_config[`USC_BIT_PAR_TYPE];
   assign parity_enable           = uart_frame_config[`USC_BIT_PAR_EN];

   // ----------------------------------------
   // Pin synchronisers and edge detect
   // ----------------------------------------
   reg  clk_s1;
   reg  clk_s2;
   reg  clk_s3;
   reg  rx_s1;
   reg  rx_s2;
   wire rise;
   wire fall;

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         clk_s1 <= 1'b0;
         clk_s2 <= 1'b0;
         clk_s3 <= 1'b0;
         rx_s1  <= 1'b1;
         rx_s2  <= 1'b1;
      end
      else
      begin
         clk_s1 <= ext_clk_pin;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
         rx_s1  <= rx_pin;
         rx_s2  <= rx_s1;
      end
   end

   assign rise = clk_s2 && !clk_s3;
   assign fall = !clk_s2 && clk_s3;

   // ----------------------------------------
   // Bit timing select
   // ----------------------------------------
   wire ext_rx_edge;
   wire ext_tx_edge;

   assign ext_rx_edge = rx_edge_select ? fall : rise;
   assign ext_tx_edge = tx_edge_select ? fall : rise;
   assign rx_bit_strobe = ext_sample_clock_enable ? (ext_rx_edge && receiver_enable)
                                                  : (dpll_sample && receiver_enable);
   assign tx_bit_strobe = ext_sample_clock_enable ? (ext_tx_edge && transmitter_enable)
                                                  : (baud_tick && transmitter_enable);

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         rx_bit <= 1'b1;
      else if (rx_bit_strobe)
         rx_bit <= rx_s2;
   end

   // ----------------------------------------
   // Transmit path through FIFO
   // ----------------------------------------
   wire [7:0] fifo_data;
   wire       fifo_valid;
   reg  [3:0] tx_cnt;
   reg  [8:0] tx_shift;
   reg        next_tx_pin;
   reg  [3:0] next_tx_cnt;
   reg  [8:0] next_tx_shift;
   wire       tx_busy;
   wire       load;

   usc_fifo #(
      .WIDTH (`USC_FIFO_WIDTH),
      .DEPTH (`USC_FIFO_DEPTH),
      .AW    (`USC_FIFO_AW)
   ) u_txq (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (load)
   );

   assign tx_busy = (tx_cnt != 4'h0);
   assign load    = tx_bit_strobe && !tx_busy && fifo_valid;

   always @*
   begin
      next_tx_pin   = tx_pin;
      next_tx_cnt   = tx_cnt;
      next_tx_shift = tx_shift;
      if (load)
      begin
         next_tx_pin   = 1'b0;
         next_tx_shift = data_size_select ? {1'b1, fifo_data} : {2'b11, fifo_data[6:0]};
         next_tx_cnt   = data_size_select ? `USC_TX_CNT_8 : `USC_TX_CNT_7;
      end
      else if (tx_bit_strobe && tx_busy)
      begin
         next_tx_pin   = tx_shift[0];
         next_tx_shift = {1'b1, tx_shift[8:1]};
         next_tx_cnt   = tx_cnt - 4'h1;
      end
   end

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tx_pin   <= 1'b1;
         tx_cnt   <= 4'h0;
         tx_shift <= 9'h1FF;
      end
      else
      begin
         tx_pin   <= next_tx_pin;
         tx_cnt   <= next_tx_cnt;
         tx_shift <= next_tx_shift;
      end
   end

   // ----------------------------------------
   // Receive path handed on
   // ----------------------------------------
   assign rx_data  = 8'h00;
   assign rx_valid = 1'b0;
endmodule // usc_top
`default_nettype wire

/* tb/usc_assertions.sv */
`default_nettype none
module usc_assertions (
   input wire logic       core_clk,
   input wire logic       nrst,
   input wire logic [3:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       receiver_enable,
   input wire logic       transmitter_enable,
   input wire logic       baud_tick,
   input wire logic       dpll_sample,
   input wire logic       ext_clk_pin,
   input wire logic       ext_sample_clock_enable,
   input wire logic       data_size_select,
   input wire logic       stop_bit_select,
   input wire logic       parity_type_select,
   input wire logic       parity_enable,
   input wire logic       tx_bit_strobe,
   input wire logic       rx_bit_strobe,
   input wire logic       rx_pin,
   input wire logic       rx_bit,
   input wire logic       tx_pin
);
   logic [1:0] edge_sel;
   wire logic  any_en = receiver_enable || transmitter_enable;
   wire logic  ext_mode = ext_sample_clock_enable;
   wire logic  cfg_rd = reg_rd && reg_addr == 4'h0;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   // Shadow of edge selects
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
         edge_sel <= 2'b00;
      else if (reg_wr && reg_addr == 4'h0 && !any_en)
         edge_sel <= reg_wdata[6:5];
   a_bit7_zero: assert property (cfg_rd |-> reg_rdata[7] == 1'b0)
      else $error("bit 7 read back set");
   a_field_map: assert property (cfg_rd |-> reg_rdata[4:0] == {ext_mode, data_size_select,
      stop_bit_select, parity_type_select, parity_enable})
      else $error("config field misplaced");
   a_cfg_locked: assert property (any_en |=> $stable({ext_mode, data_size_select,
      stop_bit_select, parity_type_select, parity_enable}))
      else $error("config changed while enabled");
   a_rx_internal: assert property (!ext_mode |-> rx_bit_strobe == (dpll_sample && receiver_enable))
      else $error("rx strobe wrong in internal mode");
   a_tx_internal: assert property (!ext_mode |-> tx_bit_strobe == (baud_tick && transmitter_enable))
      else $error("tx strobe wrong in internal mode");
   a_rx_ext_edge: assert property (ext_mode && receiver_enable && (edge_sel[0] ?
      $fell(ext_clk_pin) : $rose(ext_clk_pin)) |-> ##[1:3] rx_bit_strobe)
      else $error("rx strobe missing after pin edge");
   a_tx_ext_edge: assert property (ext_mode && transmitter_enable && (edge_sel[1] ?
      $fell(ext_clk_pin) : $rose(ext_clk_pin)) |-> ##[1:3] tx_bit_strobe)
      else $error("tx strobe missing after pin edge");
   a_ext_no_baud: assert property ((ext_mode && $stable(ext_clk_pin))[*5] |-> !tx_bit_strobe
      && !rx_bit_strobe)
      else $error("strobe without pin edge");
   a_rx_bit_take: assert property (rx_bit_strobe |=> rx_bit == $past(rx_pin, 3))
      else $error("rx bit not taken from pin");
   a_tx_pin_hold: assert property (!tx_bit_strobe |=> $stable(tx_pin))
      else $error("tx pin moved without strobe");
endmodule // usc_assertions
bind usc_top usc_assertions u_chk (.core_clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
   .reg_rdata, .receiver_enable, .transmitter_enable, .baud_tick, .dpll_sample, .ext_clk_pin,
   .ext_sample_clock_enable, .data_size_select, .stop_bit_select, .parity_type_select,
   .parity_enable, .tx_bit_strobe, .rx_bit_strobe, .rx_pin, .rx_bit, .tx_pin);
`default_nettype wire

/* tb/usc_peer.sv */
`default_nettype none
module usc_peer (
   input  wire logic       run,
   input  wire logic [7:0] half,
   output var  logic       ext_clk_pin,
   output var  logic       rx_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      ext_clk_pin = 1'b0;
      rx_pin = 1'b1;
   end
   always
   begin
      @(posedge run);
      #2;
      while (run)
      begin
         #(half);
         if (run)
         begin
            ext_clk_pin = ~ext_clk_pin;
            if (!ext_clk_pin)
               rx_pin = ~rx_pin;
         end
      end
      rx_pin = 1'b1;
   end
endmodule // usc_peer
`default_nettype wire

/* tb/usc_tb_top.sv */
`default_nettype none
module usc_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, baud_tick = 0, dpll_sample = 0;
   logic receiver_enable = 0, transmitter_enable = 0, tx_valid = 0, run = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, tx_data = 8'h00, seed = 8'h18, half = 8'h28, n;
   logic [7:0] reg_rdata, exp_q[$];
   logic ext_clk_pin, rx_pin, tx_pin, tx_ready;
   int n_fail = 0, checks_done = 0;
   usc_top DUT (.core_clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .receiver_enable, .transmitter_enable, .baud_tick, .dpll_sample, .ext_clk_pin, .rx_pin,
      .tx_pin, .tx_data, .tx_valid, .tx_ready, .rx_data(), .rx_valid(), .rx_ready(1'b1),
      .ext_sample_clock_enable(), .data_size_select(), .stop_bit_select(),
      .parity_type_select(), .parity_enable(), .tx_bit_strobe(), .rx_bit_strobe(), .rx_bit());
   usc_peer u_peer (.run, .half, .ext_clk_pin, .rx_pin);
   always #5 core_clk = ~core_clk;
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= 4'h0;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask
   always @(posedge core_clk)
   begin
      seed = lfsr(seed);
      baud_tick <= seed[0];
      dpll_sample <= seed[3];
      tx_data <= seed;
      if (reg_rd === 1'b1)
         chk(reg_rdata, exp_q.pop_front());
   end
   initial
   begin
      #100us;
      n_fail++;
      give_verdict();
   end
   initial
   begin
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      wr(8'hff);
      rd(4'h0, 8'h7f);
      rd(4'h3, 8'h00);
      receiver_enable <= 1'b1;
      wr(8'h10);
      rd(4'h0, 8'h7f);
      receiver_enable <= 1'b0;
      $display("register test done");
      wr(8'h10);
      n = 8'h00;
      tx_valid <= 1'b1;
      repeat (24)
      begin
         @(posedge core_clk);
         n = n + {7'h00, tx_valid && tx_ready};
      end
      tx_valid <= 1'b0;
      chk(n, 8'h10);
      $display("fill test done");
      for (int i = 0; i < 5; i++)
      begin
         n = i == 0 ? 8'h10 : i == 1 ? 8'h30 : i == 2 ? 8'h5f : i == 3 ? 8'h70 : 8'h0f;
         wr(n);
         rd(4'h0, n);
         half <= n[5] ? 8'h28 : 8'h50;
         receiver_enable <= 1'b1;
         transmitter_enable <= 1'b1;
         run <= n[4];
         repeat (400) @(posedge core_clk);
         run <= 1'b0;
         repeat (4) @(posedge core_clk);
         receiver_enable <= 1'b0;
         transmitter_enable <= 1'b0;
         $display("mode %h test done", n);
      end
      repeat (4) @(posedge core_clk);
      chk({6'h00, tx_pin, tx_ready}, 8'h03);
      give_verdict();
   end
endmodule // usc_tb_top
`default_nettype wire
